// ==== src/tcc_pkg.sv ====
package tcc_pkg;
    // Register index on the plain register port
    localparam int          ADDR_W          = 3;
    localparam int          DATA_W          = 16;
    localparam logic [2:0]  OFS_COUNT       = 3'h0;
    localparam logic [2:0]  OFS_CAPCOMP_A   = 3'h1;
    localparam logic [2:0]  OFS_CAPCOMP_B   = 3'h2;
    localparam logic [2:0]  OFS_RUN_CTRL    = 3'h3;
    localparam logic [2:0]  OFS_CC_SELECT   = 3'h4;
    localparam logic [2:0]  OFS_EDGE_SELECT = 3'h5;
    localparam logic [2:0]  OFS_ONESHOT     = 3'h6;

    // Field positions
    localparam int          RUN_LO_BIT      = 2;
    localparam int          RUN_HI_BIT      = 3;
    localparam int          OVF_BIT         = 0;
    localparam int          SEL_A_CAP_BIT   = 0;
    localparam int          SEL_A_TRIG_BIT  = 1;
    localparam int          SEL_B_CAP_BIT   = 2;
    localparam int          EDGE_A_LO_BIT   = 0;
    localparam int          EDGE_A_HI_BIT   = 1;
    localparam int          EDGE_B_LO_BIT   = 2;
    localparam int          EDGE_B_HI_BIT   = 3;
    localparam int          OS_EN_BIT       = 0;
    localparam int          OS_TRIG_BIT     = 1;

    // Reset values and counter maximum
    localparam logic [15:0] RST_COUNT       = 16'h0000;
    localparam logic [15:0] RST_CAPCOMP     = 16'h0000;
    localparam logic [1:0]  RST_RUN         = 2'h0;
    localparam logic [2:0]  RST_CC_SELECT   = 3'h0;
    localparam logic [3:0]  RST_EDGE_SELECT = 4'h0;
    localparam logic [15:0] COUNT_MAX       = 16'hFFFF;

    // Run-mode codes
    localparam logic [1:0]  RUN_STOP        = 2'h0;
    localparam logic [1:0]  RUN_FREE        = 2'h1;
    localparam logic [1:0]  RUN_EDGE_RST    = 2'h2;
    localparam logic [1:0]  RUN_MATCH_RST   = 2'h3;

    // Valid-edge codes
    localparam logic [1:0]  EDGE_FALL       = 2'h0;
    localparam logic [1:0]  EDGE_RISE       = 2'h1;
    localparam logic [1:0]  EDGE_NONE       = 2'h2;
    localparam logic [1:0]  EDGE_BOTH       = 2'h3;

    // Trigger channels
    localparam int          NUM_TRIG        = 2;
endpackage

// ==== src/tcc_edge_if.sv ====
interface tcc_edge_if;
    logic rise;
    logic fall;
    modport filt (output rise, output fall);
    modport core (input rise, input fall);
endinterface

// ==== src/tcc_edge_filter.sv ====
module tcc_edge_filter (
    input  wire logic clk_sys_in,
    input  wire logic rst_in,
    input  wire logic ce_in,
    input  wire logic pin_in,
    tcc_edge_if.filt  edge_io
);
    logic sync1_reg;
    logic sync2_reg;
    logic hold_reg;
    logic level_reg;
    logic accept;

    // Level accepted only after two equal samples, so a one-cycle glitch is dropped
    assign accept = (sync2_reg == hold_reg) && (hold_reg != level_reg);

    // Two-flop synchroniser, then a hold stage for the filter
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            hold_reg  <= 1'b0;
            level_reg <= 1'b0;
            edge_io.rise <= 1'b0;
            edge_io.fall <= 1'b0;
        end else if (ce_in) begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            hold_reg  <= sync2_reg;
            if (accept) begin
                level_reg <= hold_reg;
            end
            edge_io.rise <= accept && hold_reg;  // One pulse per accepted edge
            edge_io.fall <= accept && !hold_reg;
        end
    end
endmodule

// ==== src/tcc_core.sv ====
module tcc_core (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    input  wire logic [2:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    input  wire logic        trigger_input_a_in,
    input  wire logic        trigger_input_b_in,
    output logic [15:0]      rdata_out,
    output logic             match_irq_a_out,
    output logic             match_irq_b_out,
    output logic             overflow_flag_out
);
    tcc_edge_if edge_bus [tcc_pkg::NUM_TRIG] ();

    logic [15:0] timer_count_reg;
    logic [15:0] timer_count_next;
    logic [15:0] capcomp_reg_a;
    logic [15:0] capcomp_reg_b;
    logic [1:0]  run_mode_reg;
    logic        overflow_reg;
    logic [2:0]  capcomp_select_reg;
    logic [3:0]  edge_select_reg;
    logic        oneshot_en_reg;
    logic [15:0] rdata_reg;
    logic        match_a_reg;
    logic        match_b_reg;

    logic [tcc_pkg::NUM_TRIG-1:0] pins;
    logic [tcc_pkg::NUM_TRIG-1:0] rise_w;
    logic [tcc_pkg::NUM_TRIG-1:0] fall_w;

    assign pins = {trigger_input_b_in, trigger_input_a_in};

    // One filter per trigger input
    genvar gi;
    generate
        for (gi = 0; gi < tcc_pkg::NUM_TRIG; gi++) begin : g_trig
            tcc_edge_filter u_filt (
                .clk_sys_in (clk_sys_in),
                .rst_in     (rst_in),
                .ce_in      (ce_in),
                .pin_in     (pins[gi]),
                .edge_io    (edge_bus[gi])
            );
            assign rise_w[gi] = edge_bus[gi].rise;
            assign fall_w[gi] = edge_bus[gi].fall;
        end
    endgenerate

    // Field decode
    wire [1:0] edge_a_sel   = edge_select_reg[tcc_pkg::EDGE_A_HI_BIT:tcc_pkg::EDGE_A_LO_BIT];
    wire [1:0] edge_b_sel   = edge_select_reg[tcc_pkg::EDGE_B_HI_BIT:tcc_pkg::EDGE_B_LO_BIT];
    wire       a_capture    = capcomp_select_reg[tcc_pkg::SEL_A_CAP_BIT];
    wire       a_trig_b_sel = capcomp_select_reg[tcc_pkg::SEL_A_TRIG_BIT];
    wire       b_capture    = capcomp_select_reg[tcc_pkg::SEL_B_CAP_BIT];
    wire       running      = (run_mode_reg != tcc_pkg::RUN_STOP);

    // Valid-edge and opposite-edge detection per selection code
    // Code none never fires; both is its own opposite
    function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
        edge_hit = (sel == tcc_pkg::EDGE_RISE) ? r :
                   (sel == tcc_pkg::EDGE_FALL) ? f :
                   (sel == tcc_pkg::EDGE_BOTH) ? (r | f) : 1'b0;
    endfunction

    wire a_valid    = edge_hit(edge_a_sel, rise_w[0], fall_w[0]);
    wire a_opposite = edge_hit(edge_a_sel, fall_w[0], rise_w[0]);  // Swap phases
    wire b_valid    = edge_hit(edge_b_sel, rise_w[1], fall_w[1]);

    // Write decode
    wire wr_a      = wr_in && (addr_in == tcc_pkg::OFS_CAPCOMP_A);
    wire wr_b      = wr_in && (addr_in == tcc_pkg::OFS_CAPCOMP_B);
    wire wr_run    = wr_in && (addr_in == tcc_pkg::OFS_RUN_CTRL);
    wire wr_sel    = wr_in && (addr_in == tcc_pkg::OFS_CC_SELECT);
    wire wr_edge   = wr_in && (addr_in == tcc_pkg::OFS_EDGE_SELECT);
    wire wr_os     = wr_in && (addr_in == tcc_pkg::OFS_ONESHOT);
    wire os_sw_trg = wr_os && wdata_in[tcc_pkg::OS_TRIG_BIT];

    // Capture triggers, only honoured in capture mode
    wire cap_a_trig = a_trig_b_sel ? b_valid : a_opposite;
    wire cap_a      = a_capture && cap_a_trig;
    wire cap_b      = b_capture && a_valid;

    // Compare matches, valid only while counting
    wire hit_a = running && !a_capture && (timer_count_reg == capcomp_reg_a);
    wire hit_b = running && !b_capture && (timer_count_reg == capcomp_reg_b);

    // Restart sources: edge and match per run mode, one-shot by its own enable
    wire rst_edge    = (run_mode_reg == tcc_pkg::RUN_EDGE_RST) && a_valid;
    wire rst_match   = (run_mode_reg == tcc_pkg::RUN_MATCH_RST) && hit_a;
    wire rst_oneshot = oneshot_en_reg && (os_sw_trg || a_valid);
    wire restart     = rst_edge || rst_match || rst_oneshot;
    wire wrap        = running && !restart && (timer_count_reg == tcc_pkg::COUNT_MAX);

    // Counter next value: cleared when stopped or restarted
    assign timer_count_next = !running ? tcc_pkg::RST_COUNT :
                              restart  ? tcc_pkg::RST_COUNT :
                              16'(timer_count_reg + 16'h0001);

    // Read mux: counter masked to zero while stopped, no side effects
    wire [15:0] rd_mux =
        (addr_in == tcc_pkg::OFS_COUNT)       ? (running ? timer_count_reg : 16'h0000) :
        (addr_in == tcc_pkg::OFS_CAPCOMP_A)   ? capcomp_reg_a :
        (addr_in == tcc_pkg::OFS_CAPCOMP_B)   ? capcomp_reg_b :
        (addr_in == tcc_pkg::OFS_RUN_CTRL)    ? {12'h000, run_mode_reg, 1'b0, overflow_reg} :
        (addr_in == tcc_pkg::OFS_CC_SELECT)   ? {13'h0000, capcomp_select_reg} :
        (addr_in == tcc_pkg::OFS_EDGE_SELECT) ? {12'h000, edge_select_reg} :
        (addr_in == tcc_pkg::OFS_ONESHOT)     ? {15'h0000, oneshot_en_reg} :
        16'h0000;

    // Counter
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            timer_count_reg <= tcc_pkg::RST_COUNT;
        end else if (ce_in) begin
            timer_count_reg <= timer_count_next;
        end
    end

    // Capture/compare A: capture beats a software write in the same cycle
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            capcomp_reg_a <= tcc_pkg::RST_CAPCOMP;
        end else if (ce_in) begin
            if (cap_a) begin
                capcomp_reg_a <= timer_count_reg;
            end else if (wr_a) begin
                capcomp_reg_a <= wdata_in;
            end
        end
    end

    // Capture/compare B
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            capcomp_reg_b <= tcc_pkg::RST_CAPCOMP;
        end else if (ce_in) begin
            if (cap_b) begin
                capcomp_reg_b <= timer_count_reg;
            end else if (wr_b) begin
                capcomp_reg_b <= wdata_in;
            end
        end
    end

    // Run control and overflow flag; a wrap beats a software clear
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            run_mode_reg <= tcc_pkg::RST_RUN;
            overflow_reg <= 1'b0;
        end else if (ce_in) begin
            if (wr_run) begin
                run_mode_reg <= wdata_in[tcc_pkg::RUN_HI_BIT:tcc_pkg::RUN_LO_BIT];
            end
            if (wrap) begin
                overflow_reg <= 1'b1;
            end else if (wr_run) begin
                overflow_reg <= wdata_in[tcc_pkg::OVF_BIT];
            end
        end
    end

    // Mode selection registers
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            capcomp_select_reg <= tcc_pkg::RST_CC_SELECT;
            edge_select_reg    <= tcc_pkg::RST_EDGE_SELECT;
            oneshot_en_reg     <= 1'b0;
        end else if (ce_in) begin
            if (wr_sel) begin
                capcomp_select_reg <= wdata_in[2:0];
            end
            if (wr_edge) begin
                edge_select_reg <= wdata_in[3:0];
            end
            if (wr_os) begin
                oneshot_en_reg <= wdata_in[tcc_pkg::OS_EN_BIT];
            end
        end
    end

    // Read data and match pulses, all registered
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            rdata_reg   <= 16'h0000;
            match_a_reg <= 1'b0;
            match_b_reg <= 1'b0;
        end else if (ce_in) begin
            rdata_reg   <= rd_in ? rd_mux : 16'h0000;
            match_a_reg <= hit_a;
            match_b_reg <= hit_b;
        end
    end

    assign rdata_out         = rdata_reg;
    assign match_irq_a_out   = match_a_reg;
    assign match_irq_b_out   = match_b_reg;
    assign overflow_flag_out = overflow_reg;

    // Checks on the block's own behaviour
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    property p_count_incr;
        ce_in && running && !restart |=> timer_count_reg == 16'($past(timer_count_reg) + 16'h0001);
    endproperty
    a_count_incr: assert property (p_count_incr) else $error("counter did not advance by one");

    property p_read_stopped;
        rd_in && addr_in == tcc_pkg::OFS_COUNT && !running && ce_in |=> rdata_out == 16'h0000;
    endproperty
    a_read_stopped: assert property (p_read_stopped) else $error("stopped counter read not zero");

    property p_restart_match;
        ce_in && run_mode_reg == tcc_pkg::RUN_MATCH_RST && hit_a |=> timer_count_reg == 16'h0000;
    endproperty
    a_restart_match: assert property (p_restart_match) else $error("match restart missed");

    property p_read_no_load;
        ce_in && rd_in && !cap_b && !wr_b |=> $stable(capcomp_reg_b);
    endproperty
    a_read_no_load: assert property (p_read_no_load) else $error("read disturbed register B");

    // Own disable clause: the default one would switch off every attempt
    property p_reset_clear;
        disable iff (1'h0)
        rst_in |=> timer_count_reg == 16'h0000 && capcomp_reg_a == 16'h0000 && capcomp_reg_b == 16'h0000;
    endproperty
    a_reset_clear: assert property (@(posedge clk_sys_in) p_reset_clear) else $error("reset did not clear");

    property p_match_a;
        ce_in && running && !a_capture && timer_count_reg == capcomp_reg_a |=> match_irq_a_out;
    endproperty
    a_match_a: assert property (p_match_a) else $error("match A pulse missing");

    property p_hold_a;
        ce_in && !a_capture && !wr_a |=> $stable(capcomp_reg_a);
    endproperty
    a_hold_a: assert property (p_hold_a) else $error("compare A changed without write");

    property p_capture_a;
        ce_in && a_capture && cap_a_trig |=> capcomp_reg_a == $past(timer_count_reg);
    endproperty
    a_capture_a: assert property (p_capture_a) else $error("capture A lost");

    property p_match_b;
        ce_in && running && !b_capture && timer_count_reg == capcomp_reg_b |=> match_irq_b_out;
    endproperty
    a_match_b: assert property (p_match_b) else $error("match B pulse missing");

    property p_capture_b;
        ce_in && b_capture && a_valid |=> capcomp_reg_b == $past(timer_count_reg);
    endproperty
    a_capture_b: assert property (p_capture_b) else $error("capture B lost");

    property p_overflow;
        ce_in && wrap |=> overflow_flag_out && timer_count_reg == 16'h0000;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not flagged");

    property p_stop_clear;
        ce_in && !running ##1 ce_in |-> timer_count_reg == 16'h0000;
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("stopped counter not zero");

    // Read path and register hold
    property p_read_count_run;
        ce_in && rd_in && addr_in == tcc_pkg::OFS_COUNT && running |=> rdata_out == $past(timer_count_reg);
    endproperty
    a_read_count_run: assert property (p_read_count_run) else $error("running counter read wrong");

    property p_hold_b;
        ce_in && !b_capture && !wr_b |=> $stable(capcomp_reg_b);
    endproperty
    a_hold_b: assert property (p_hold_b) else $error("compare B changed without write");

    // Sticky overflow, cleared only by software
    property p_overflow_sticky;
        ce_in && overflow_flag_out && !wr_run |=> overflow_flag_out;
    endproperty
    a_overflow_sticky: assert property (p_overflow_sticky) else $error("overflow flag dropped");

    // Restart sources give zero in the next cycle
    property p_restart_edge;
        ce_in && rst_edge |=> timer_count_reg == 16'h0000;
    endproperty
    a_restart_edge: assert property (p_restart_edge) else $error("edge restart missed");

    property p_restart_oneshot;
        ce_in && rst_oneshot |=> timer_count_reg == 16'h0000;
    endproperty
    a_restart_oneshot: assert property (p_restart_oneshot) else $error("one-shot restart missed");

    // Match pulses only on equality, never while stopped
    property p_match_a_pulse;
        ce_in && !hit_a |=> !match_irq_a_out;
    endproperty
    a_match_a_pulse: assert property (p_match_a_pulse) else $error("match A pulse without equality");

    property p_match_b_pulse;
        ce_in && !hit_b |=> !match_irq_b_out;
    endproperty
    a_match_b_pulse: assert property (p_match_b_pulse) else $error("match B pulse without equality");

    property p_stop_no_match;
        ce_in && !running |=> !match_irq_a_out && !match_irq_b_out;
    endproperty
    a_stop_no_match: assert property (p_stop_no_match) else $error("match pulse while stopped");

    // Filter pulses last one cycle, so each edge acts once
    property p_edge_once;
        ce_in && (rise_w | fall_w) != 2'h0 |=> (rise_w | fall_w) == 2'h0;
    endproperty
    a_edge_once: assert property (p_edge_once) else $error("edge pulse longer than one cycle");

    // Main scenarios
    c_wrap:      cover property (ce_in && wrap);
    c_capture_b: cover property (ce_in && cap_b);
    c_edge_rst:  cover property (ce_in && rst_edge);
    c_match_rst: cover property (ce_in && rst_match ##1 timer_count_reg == 16'h0000);
    c_oneshot:   cover property (ce_in && rst_oneshot);
endmodule

// ==== testbench/tcc_pin_model.sv ====
// Far-side model of the two external trigger pins
module tcc_pin_model (
    input  wire logic clk_sys_in,
    output logic      trigger_input_a_out,
    output logic      trigger_input_b_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Both pins idle low from time zero
    initial begin
        trigger_input_a_out = 1'b0;
        trigger_input_b_out = 1'b0;
    end

    // New level just after an edge, held for the caller's span (short or slow)
    task automatic drive(input bit sel_b, input logic level, input int hold);
        @(posedge clk_sys_in);
        if (sel_b) begin
            trigger_input_b_out <= level; // shared pin used only as trigger input
        end else begin
            trigger_input_a_out <= level;
        end
        repeat (hold) @(posedge clk_sys_in);
    endtask
endmodule

// ==== testbench/test_timer16_capture_compare_core.sv ====
module test_timer16_capture_compare_core;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_sys_in = 1'b0;
    logic        rst_in;
    logic        ce_in;
    logic [2:0]  addr_in;
    logic [15:0] wdata_in;
    logic        wr_in;
    logic        rd_in;
    logic        pin_a;
    logic        pin_b;
    logic [15:0] rdata_out;
    logic        match_irq_a_out;
    logic        match_irq_b_out;
    logic        overflow_flag_out;
    int          mismatches = 0;
    int          tests_run  = 0;
    int          n;
    logic [15:0] v;
    logic [15:0] c0;
    logic [15:0] c1;

    // 200 MHz system clock
    always #2.5 clk_sys_in = ~clk_sys_in;

    tcc_core i_tcc_core (
        .clk_sys_in         (clk_sys_in),
        .rst_in             (rst_in),
        .ce_in              (ce_in),
        .addr_in            (addr_in),
        .wdata_in           (wdata_in),
        .wr_in              (wr_in),
        .rd_in              (rd_in),
        .trigger_input_a_in (pin_a),
        .trigger_input_b_in (pin_b),
        .rdata_out          (rdata_out),
        .match_irq_a_out    (match_irq_a_out),
        .match_irq_b_out    (match_irq_b_out),
        .overflow_flag_out  (overflow_flag_out)
    );

    tcc_pin_model i_tcc_pin_model (
        .clk_sys_in          (clk_sys_in),
        .trigger_input_a_out (pin_a),
        .trigger_input_b_out (pin_b)
    );

    // Verdict in one place, shared by the tests and the watchdog
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Range test folded into the one compare task
    task automatic chk_rng(input string name, input logic [15:0] seen, input logic [15:0] lo,
                           input logic [15:0] hi);
        chk(name, {15'h0000, (seen >= lo && seen <= hi)}, 16'h0001);
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge clk_sys_in);
        wr_in    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
        @(posedge clk_sys_in);
        addr_in <= a;
        rd_in   <= 1'b1;
        @(posedge clk_sys_in);
        rd_in   <= 1'b0;
        #1;
        d = rdata_out;
    endtask

    // Bounded wait for match A (0), match B (1) or overflow (2)
    task automatic wait_hi(input int sel, input int limit, output int cnt);
        logic s;
        cnt = 0;
        s   = 1'b0;
        while (s !== 1'b1 && cnt < limit) begin
            @(posedge clk_sys_in);
            #1;
            cnt++;
            s = (sel == 0) ? match_irq_a_out : (sel == 1) ? match_irq_b_out : overflow_flag_out;
        end
        chk("wait_flag", {15'h0000, s}, 16'h0001);
    endtask

    function automatic logic [15:0] run_w(input logic [1:0] m);
        return {12'h000, m, 2'h0};
    endfunction

    // Watchdog: overflow wait dominates the run
    initial begin
        repeat (90000) @(posedge clk_sys_in);
        mismatches++;
        close_out();
    end

    initial begin
        rst_in   = 1'b1;
        ce_in    = 1'b1;
        addr_in  = 3'h0;
        wdata_in = 16'h0000;
        wr_in    = 1'b0;
        rd_in    = 1'b0;
        repeat (8) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        // Every index reads zero after reset, unmapped one included
        for (int i = 0; i < 8; i++) begin
            rd_reg(i[2:0], v);
            chk("reset_value", v, 16'h0000);
        end
        wr_reg(3'h7, 16'hFFFF);
        rd_reg(3'h7, v);
        chk("unmapped", v, 16'h0000);
        // Whole-word writes while stopped
        wr_reg(tcc_pkg::OFS_CAPCOMP_A, 16'h0020);
        rd_reg(tcc_pkg::OFS_CAPCOMP_A, v);
        chk("reg_a_rw", v, 16'h0020);
        wr_reg(tcc_pkg::OFS_CAPCOMP_B, 16'h0040);
        rd_reg(tcc_pkg::OFS_CAPCOMP_B, v);
        chk("reg_b_rw", v, 16'h0040);
        // Free run: B compare pulse, count steps, compare register B holds
        wr_reg(tcc_pkg::OFS_RUN_CTRL, run_w(tcc_pkg::RUN_FREE));
        wait_hi(1, 200, n);
        chk_rng("match_b_time", n[15:0], 16'h003E, 16'h0044);
        @(posedge clk_sys_in);
        #1;
        chk("match_b_pulse", {15'h0000, match_irq_b_out}, 16'h0000);
        rd_reg(tcc_pkg::OFS_COUNT, c0);
        rd_reg(tcc_pkg::OFS_COUNT, c1);
        chk("count_step", c1 - c0, 16'h0002);
        rd_reg(tcc_pkg::OFS_CAPCOMP_B, v);
        chk("read_no_load", v, 16'h0040);
        // Clock enable low for 20 edges freezes the count
        rd_reg(tcc_pkg::OFS_COUNT, c0);
        @(posedge clk_sys_in);
        ce_in <= 1'b0;
        repeat (20) @(posedge clk_sys_in);
        ce_in <= 1'b1;
        rd_reg(tcc_pkg::OFS_COUNT, c1);
        chk("ce_freeze", c1 - c0, 16'h0003);
        for (int i = 0; i < 4; i++) begin
            i_tcc_pin_model.drive(i[0], ~i[1], 6);
        end
        rd_reg(tcc_pkg::OFS_CAPCOMP_A, v);
        chk("a_cmp_ignores", v, 16'h0020);
        rd_reg(tcc_pkg::OFS_CAPCOMP_B, v);
        chk("b_cmp_ignores", v, 16'h0040);
        // Stop clears count, then match restart period is A plus one
        wr_reg(tcc_pkg::OFS_RUN_CTRL, run_w(tcc_pkg::RUN_STOP));
        rd_reg(tcc_pkg::OFS_COUNT, v);
        chk("stop_count", v, 16'h0000);
        wr_reg(tcc_pkg::OFS_RUN_CTRL, run_w(tcc_pkg::RUN_MATCH_RST));
        wait_hi(0, 200, n);
        wait_hi(0, 100, n);
        chk("match_period", n[15:0], 16'h0021);
        @(posedge clk_sys_in);
        #1;
        chk("match_a_pulse", {15'h0000, match_irq_a_out}, 16'h0000);
        // Edge restart, B captures on the rising edge of input A
        wr_reg(tcc_pkg::OFS_RUN_CTRL, run_w(tcc_pkg::RUN_STOP));
        wr_reg(tcc_pkg::OFS_EDGE_SELECT, 16'h0001);
        wr_reg(tcc_pkg::OFS_CC_SELECT, 16'h0004);
        wr_reg(tcc_pkg::OFS_RUN_CTRL, run_w(tcc_pkg::RUN_EDGE_RST));
        repeat (40) @(posedge clk_sys_in);
        rd_reg(tcc_pkg::OFS_COUNT, c0);
        i_tcc_pin_model.drive(1'b0, 1'b1, 12);
        rd_reg(tcc_pkg::OFS_CAPCOMP_B, v);
        chk_rng("b_capture", v, c0, c0 + 16'h0014);
        rd_reg(tcc_pkg::OFS_COUNT, c1);
        chk_rng("edge_restart", c1, 16'h0000, 16'h0013);
        i_tcc_pin_model.drive(1'b0, 1'b0, 6);
        // A captures on the edge opposite to input A's valid edge only
        wr_reg(tcc_pkg::OFS_RUN_CTRL, run_w(tcc_pkg::RUN_STOP));
        wr_reg(tcc_pkg::OFS_CAPCOMP_A, 16'h0000);
        wr_reg(tcc_pkg::OFS_CC_SELECT, 16'h0001);
        wr_reg(tcc_pkg::OFS_RUN_CTRL, run_w(tcc_pkg::RUN_FREE));
        i_tcc_pin_model.drive(1'b0, 1'b1, 12);
        rd_reg(tcc_pkg::OFS_CAPCOMP_A, v);
        chk("a_valid_edge_no_cap", v, 16'h0000);
        rd_reg(tcc_pkg::OFS_COUNT, c0);
        i_tcc_pin_model.drive(1'b0, 1'b0, 12);
        rd_reg(tcc_pkg::OFS_CAPCOMP_A, v);
        chk_rng("a_capture_opp", v, c0, c0 + 16'h0014);
        // A captures on the valid edge of input B, value then stays
        wr_reg(tcc_pkg::OFS_RUN_CTRL, run_w(tcc_pkg::RUN_STOP));
        wr_reg(tcc_pkg::OFS_CC_SELECT, 16'h0003);
        wr_reg(tcc_pkg::OFS_EDGE_SELECT, 16'h0005);
        wr_reg(tcc_pkg::OFS_RUN_CTRL, run_w(tcc_pkg::RUN_FREE));
        repeat (20) @(posedge clk_sys_in);
        rd_reg(tcc_pkg::OFS_COUNT, c0);
        i_tcc_pin_model.drive(1'b1, 1'b1, 12);
        rd_reg(tcc_pkg::OFS_CAPCOMP_A, v);
        chk_rng("a_capture_b", v, c0, c0 + 16'h0014);
        repeat (30) @(posedge clk_sys_in);
        rd_reg(tcc_pkg::OFS_CAPCOMP_A, c1);
        chk("a_capture_held", c1, v);
        i_tcc_pin_model.drive(1'b1, 1'b0, 6);
        // Stop before leaving capture mode, fresh compare value, then wrap
        wr_reg(tcc_pkg::OFS_RUN_CTRL, run_w(tcc_pkg::RUN_STOP));
        wr_reg(tcc_pkg::OFS_CC_SELECT, 16'h0000);
        wr_reg(tcc_pkg::OFS_CAPCOMP_A, 16'h1234);
        wr_reg(tcc_pkg::OFS_RUN_CTRL, run_w(tcc_pkg::RUN_FREE));
        wait_hi(2, 70000, n);
        chk("wrap_time", 16'(n - 1), 16'hFFFF);
        rd_reg(tcc_pkg::OFS_RUN_CTRL, v);
        chk("ovf_set", v, 16'h0005);
        wr_reg(tcc_pkg::OFS_RUN_CTRL, run_w(tcc_pkg::RUN_FREE));
        rd_reg(tcc_pkg::OFS_RUN_CTRL, v);
        chk("ovf_clear", v, 16'h0004);
        // B captures on both edges of input A, then on neither
        wr_reg(tcc_pkg::OFS_CC_SELECT, 16'h0004);
        wr_reg(tcc_pkg::OFS_EDGE_SELECT, 16'h0003);
        rd_reg(tcc_pkg::OFS_COUNT, c0);
        i_tcc_pin_model.drive(1'b0, 1'b1, 12);
        rd_reg(tcc_pkg::OFS_CAPCOMP_B, v);
        chk_rng("b_cap_both_rise", v, c0, c0 + 16'h0014);
        rd_reg(tcc_pkg::OFS_COUNT, c0);
        i_tcc_pin_model.drive(1'b0, 1'b0, 12);
        rd_reg(tcc_pkg::OFS_CAPCOMP_B, v);
        chk_rng("b_cap_both_fall", v, c0, c0 + 16'h0014);
        wr_reg(tcc_pkg::OFS_EDGE_SELECT, 16'h0002);
        i_tcc_pin_model.drive(1'b0, 1'b1, 12);
        rd_reg(tcc_pkg::OFS_CAPCOMP_B, c1);
        chk("b_cap_none", c1, v);
        i_tcc_pin_model.drive(1'b0, 1'b0, 6);
        // One-shot software trigger restarts the count
        repeat (50) @(posedge clk_sys_in);
        wr_reg(tcc_pkg::OFS_ONESHOT, 16'h0001);
        wr_reg(tcc_pkg::OFS_ONESHOT, 16'h0003);
        rd_reg(tcc_pkg::OFS_COUNT, v);
        chk_rng("oneshot_restart", v, 16'h0000, 16'h0007);
        wr_reg(tcc_pkg::OFS_RUN_CTRL, run_w(tcc_pkg::RUN_STOP));
        rd_reg(tcc_pkg::OFS_COUNT, v);
        chk("final_stop", v, 16'h0000);
        close_out();
    end
endmodule
